// file: inc/dsph_params.svh
// constants of the deep standby pin hold block
//
// Function
// RQ1: record waking source in wake flag register
// RQ2: hold pin level and direction during standby
// RQ3: external boot releases memory control pins early
// RQ4: other pins held until read-1 then write-0
// RQ5: on-chip boot keeps all pins held likewise
// RQ6: each occurring enabled source sets own flag
// RQ7: software reconfigures peripherals before releasing hold
// RQ8: hold flag reads 1 while any retention
`ifndef DSPH_PARAMS_SVH
`define DSPH_PARAMS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define DSPH_GEN_PINS 16
`define DSPH_MEM_PINS 4
`define DSPH_SRC_W    3

// ----------------------------------------------------------------
// wake source flag positions
// ----------------------------------------------------------------
`define DSPH_SRC_NMI 0
`define DSPH_SRC_RTC 1
`define DSPH_SRC_PIN 2

// ----------------------------------------------------------------
// reset values and the hold-on level
// ----------------------------------------------------------------
`define DSPH_FLAGS_RST 3'h0
`define DSPH_HOLD_OFF  1'h0
`define DSPH_HOLD_ON   1'h1

`endif

// file: inc/dsph_pkg.sv
// types shared by the deep standby pin hold block
`default_nettype none
`include "dsph_params.svh"

package dsph_pkg;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DSPH_RUN,
        DSPH_STANDBY,
        DSPH_HELD
    } dsph_state_t;

    // ----------------------------------------------------------------
    // state of the sequencer
    // ----------------------------------------------------------------
    typedef struct packed {
        dsph_state_t             state;
        logic [`DSPH_SRC_W-1:0]  flags;
        logic                    hold_flag;
        logic                    gen_hold;
        logic                    mem_hold;
        logic                    armed;
        logic                    pin_prev;
        logic                    in_standby;
    } dsph_seq_t;

endpackage
`default_nettype wire

// file: core/dsph_hold_cell.sv
// pin level and direction retention cell with registered outputs
`timescale 1ns/10ps
`default_nettype none
`include "dsph_params.svh"

module dsph_hold_cell
    import dsph_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         hold,
    input  wire logic [W-1:0] live_out,
    input  wire logic [W-1:0] live_oe,
    output var  logic [W-1:0] pin_out,
    output var  logic [W-1:0] pin_oe
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] held_out;
        logic [W-1:0] held_oe;
        logic [W-1:0] out;
        logic [W-1:0] oe;
    } dsph_cell_t;

    dsph_cell_t cur;
    dsph_cell_t next_cur;

    // the snapshot tracks live control every cycle until hold rises,
    // so it keeps the state from just before the hold took effect
    always_comb begin
        next_cur = cur;
        if (!hold) begin
            next_cur.held_out = live_out;
            next_cur.held_oe  = live_oe;
        end
        next_cur.out = hold ? cur.held_out : live_out; // RQ2
        next_cur.oe  = hold ? cur.held_oe  : live_oe;  // RQ2
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign pin_out = cur.out;
    assign pin_oe  = cur.oe;

endmodule
`default_nettype wire

// file: core/dsph_seq.sv
// deep standby wake source capture and pin hold release sequencer
`timescale 1ns/10ps
`default_nettype none
`include "dsph_params.svh"

module dsph_seq
    import dsph_pkg::*;
(
    // ----------------------------------------------------------------
    // clock and reset
    // ----------------------------------------------------------------
    input  wire logic                      sys_clk,
    input  wire logic                      rstn,
    // ----------------------------------------------------------------
    // standby entry and wake sources
    // ----------------------------------------------------------------
    input  wire logic                      standby_req,
    input  wire logic [`DSPH_SRC_W-1:0]    wake_en,
    input  wire logic                      wake_nmi,
    input  wire logic                      wake_rtc,
    input  wire logic                      wake_pin,
    input  wire logic                      boot_ext,
    // ----------------------------------------------------------------
    // live pin control from the port logic
    // ----------------------------------------------------------------
    input  wire logic [`DSPH_GEN_PINS-1:0] gen_out_in,
    input  wire logic [`DSPH_GEN_PINS-1:0] gen_oe_in,
    input  wire logic [`DSPH_MEM_PINS-1:0] mem_out_in,
    input  wire logic [`DSPH_MEM_PINS-1:0] mem_oe_in,
    // ----------------------------------------------------------------
    // software strobes
    // ----------------------------------------------------------------
    input  wire logic                      hold_rd,
    input  wire logic                      hold_wr,
    input  wire logic                      hold_wdata,
    input  wire logic [`DSPH_SRC_W-1:0]    src_clr,
    // ----------------------------------------------------------------
    // pins and status
    // ----------------------------------------------------------------
    output var  logic [`DSPH_GEN_PINS-1:0] gen_out,
    output var  logic [`DSPH_GEN_PINS-1:0] gen_oe,
    output var  logic [`DSPH_MEM_PINS-1:0] mem_out,
    output var  logic [`DSPH_MEM_PINS-1:0] mem_oe,
    output var  logic [`DSPH_SRC_W-1:0]    standby_wake_source_flags,
    output var  logic                      pin_hold_flag,
    output var  logic                      in_standby
);

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    // rstn may fall at any time, but the logic only leaves reset on an edge
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'h0;
            rst_n    <= 1'h0;
        end else begin
            rst_meta <= 1'h1;
            rst_n    <= rst_meta;
        end
    end

    // ----------------------------------------------------------------
    // wake decode
    // ----------------------------------------------------------------
    // pin wake is a change of level, so the last sample is compared
    function automatic logic [`DSPH_SRC_W-1:0] wake_hits(
        input logic [`DSPH_SRC_W-1:0] en,
        input logic                   nmi,
        input logic                   rtc,
        input logic                   pin_chg
    );
        logic [`DSPH_SRC_W-1:0] raw;
        raw = '0;
        raw[`DSPH_SRC_NMI] = nmi;
        raw[`DSPH_SRC_RTC] = rtc;
        raw[`DSPH_SRC_PIN] = pin_chg;
        return raw & en;
    endfunction

    // ----------------------------------------------------------------
    // release decode
    // ----------------------------------------------------------------
    // a read only arms while software can see the flag at 1
    function automatic logic arm_read(
        input logic rd,
        input logic flag
    );
        return rd && flag;
    endfunction

    // a write of 1, or a write before the arming read, changes nothing
    function automatic logic release_write(
        input logic wr,
        input logic wdata,
        input logic armed
    );
        return wr && !wdata && armed;
    endfunction

    dsph_seq_t cur;
    dsph_seq_t next_cur;
    logic [`DSPH_SRC_W-1:0] hits;
    logic                   arm;
    logic                   rel;

    always_comb begin
        hits = wake_hits(wake_en, wake_nmi, wake_rtc, wake_pin ^ cur.pin_prev);
        arm  = arm_read(hold_rd, cur.hold_flag);
        rel  = release_write(hold_wr, hold_wdata, cur.armed);
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        next_cur.pin_prev = wake_pin;
        // a clear never drops a flag set in the same cycle
        next_cur.flags = cur.flags & ~src_clr;
        case (cur.state)
            DSPH_RUN: begin
                if (standby_req) begin
                    next_cur.state      = DSPH_STANDBY;
                    next_cur.gen_hold   = `DSPH_HOLD_ON; // RQ2
                    next_cur.mem_hold   = `DSPH_HOLD_ON; // RQ2
                    next_cur.hold_flag  = `DSPH_HOLD_ON; // RQ8
                    next_cur.armed      = 1'h0;
                    next_cur.in_standby = 1'h1;
                    // stale sources from an earlier wake would mislead software
                    next_cur.flags      = `DSPH_FLAGS_RST;
                end
            end
            DSPH_STANDBY: begin
                if (|hits) begin
                    next_cur.state      = DSPH_HELD;
                    // a clear in the wake cycle still drops only older flags
                    next_cur.flags      = next_cur.flags | hits; // RQ1 RQ6
                    next_cur.in_standby = 1'h0;
                    // fetches from external memory need its control pins back
                    if (boot_ext) begin
                        next_cur.mem_hold = `DSPH_HOLD_OFF; // RQ3
                    end // else memory pins stay held: RQ5
                end
            end
            DSPH_HELD: begin
                // reading the flag as 1 arms the release
                if (arm) begin
                    next_cur.armed = 1'h1; // RQ4
                end
                // software has restored its peripherals before this write
                if (rel) begin
                    next_cur.state     = DSPH_RUN; // RQ4 RQ7
                    next_cur.gen_hold  = `DSPH_HOLD_OFF; // RQ4
                    next_cur.mem_hold  = `DSPH_HOLD_OFF; // RQ5
                    next_cur.hold_flag = `DSPH_HOLD_OFF; // RQ8
                    next_cur.armed     = 1'h0;
                end
            end
            // unreachable codes fall back to normal running
            default: begin
                next_cur.state = DSPH_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur.state      <= DSPH_RUN;
            cur.flags      <= `DSPH_FLAGS_RST;
            cur.hold_flag  <= `DSPH_HOLD_OFF;
            cur.gen_hold   <= `DSPH_HOLD_OFF;
            cur.mem_hold   <= `DSPH_HOLD_OFF;
            cur.armed      <= 1'h0;
            cur.pin_prev   <= 1'h0;
            cur.in_standby <= 1'h0;
        end else begin
            cur <= next_cur;
        end
    end

    // ----------------------------------------------------------------
    // pin retention
    // ----------------------------------------------------------------
    // general pins stay held until software completes the release
    dsph_hold_cell #(
        .W (`DSPH_GEN_PINS)
    ) u_gen_hold (
        .clk      (sys_clk),
        .rst_n    (rst_n),
        .hold     (cur.gen_hold),
        .live_out (gen_out_in),
        .live_oe  (gen_oe_in),
        .pin_out  (gen_out),
        .pin_oe   (gen_oe)
    );

    // ----------------------------------------------------------------
    // memory control pins
    // ----------------------------------------------------------------
    // these may drop their hold at wake, ahead of the general pins
    dsph_hold_cell #(
        .W (`DSPH_MEM_PINS)
    ) u_mem_hold (
        .clk      (sys_clk),
        .rst_n    (rst_n),
        .hold     (cur.mem_hold),
        .live_out (mem_out_in),
        .live_oe  (mem_oe_in),
        .pin_out  (mem_out),
        .pin_oe   (mem_oe)
    );

    // ----------------------------------------------------------------
    // status outputs
    // ----------------------------------------------------------------
    assign standby_wake_source_flags = cur.flags;
    assign pin_hold_flag             = cur.hold_flag;
    assign in_standby                = cur.in_standby;

endmodule
`default_nettype wire

// file: bench/dsph_seq_checker.sv
// assertions on the ports of the deep standby pin hold sequencer
`timescale 1ns/10ps
`default_nettype none
`include "dsph_params.svh"
module dsph_seq_checker import dsph_pkg::*; (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        standby_req,
    input wire logic [2:0]  wake_en,
    input wire logic        wake_nmi,
    input wire logic        wake_rtc,
    input wire logic        wake_pin,
    input wire logic        boot_ext,
    input wire logic [15:0] gen_out_in,
    input wire logic [3:0]  mem_out_in,
    input wire logic        hold_rd,
    input wire logic        hold_wr,
    input wire logic        hold_wdata,
    input wire logic [2:0]  src_clr,
    input wire logic [15:0] gen_out,
    input wire logic [15:0] gen_oe,
    input wire logic [3:0]  mem_out,
    input wire logic [2:0]  standby_wake_source_flags,
    input wire logic        pin_hold_flag,
    input wire logic        in_standby
);
    // ----------------------------------------------------------------
    // helpers and checks
    // ----------------------------------------------------------------
    logic       pin_q;
    logic [2:0] hits_q;
    wire  logic [2:0] hits = wake_en & {wake_pin ^ pin_q, wake_rtc, wake_nmi};
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pin_q <= 1'b0;
            hits_q <= 3'h0;
        end else begin
            pin_q <= wake_pin;
            hits_q <= hits;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence s_read;
        pin_hold_flag && !in_standby && hold_rd;
    endsequence
    sequence s_clear;
        hold_wr && !hold_wdata;
    endsequence
    a_entry_hold: assert property (!in_standby && !pin_hold_flag && standby_req |=>
        in_standby && pin_hold_flag && standby_wake_source_flags == 3'h0) else $error("entry");
    a_gen_frozen: assert property (pin_hold_flag && $past(pin_hold_flag) |->
        $stable(gen_out) && $stable(gen_oe)) else $error("general pins moved");
    a_follow_live: assert property (!pin_hold_flag && !$past(pin_hold_flag) |->
        gen_out == $past(gen_out_in) && mem_out == $past(mem_out_in)) else $error("not live");
    a_mem_early: assert property ($fell(in_standby) && boot_ext |=>
        mem_out == $past(mem_out_in)) else $error("memory pins not released");
    a_mem_held: assert property (pin_hold_flag && $past(pin_hold_flag) &&
        (in_standby || !boot_ext) |-> $stable(mem_out)) else $error("memory pins moved");
    a_wake_flags: assert property (in_standby && hits != 3'h0 |=>
        !in_standby && standby_wake_source_flags == hits_q) else $error("wake flags");
    a_no_stray: assert property (!in_standby && !standby_req && src_clr == 3'h0 |=>
        $stable(standby_wake_source_flags)) else $error("flag set outside standby");
    a_release_seq: assert property (s_read ##1 s_clear |=> !pin_hold_flag)
        else $error("hold not released");
    a_hold_keep: assert property (pin_hold_flag && !(hold_wr && !hold_wdata) |=>
        pin_hold_flag) else $error("hold dropped");
endmodule
`default_nettype wire

// file: bench/tb_dsph_seq.sv
// self-checking bench of the deep standby pin hold sequencer
`timescale 1ns/10ps
`default_nettype none
`include "dsph_params.svh"
module tb_dsph_seq import dsph_pkg::*; ;
    // ----------------------------------------------------------------
    // stimulus and scenarios
    // ----------------------------------------------------------------
    logic        sys_clk = 1'b0, rstn = 1'b0, standby_req = 1'b0, boot_ext = 1'b0;
    logic        wake_nmi = 1'b0, wake_rtc = 1'b0, wake_pin = 1'b0;
    logic        hold_rd = 1'b0, hold_wr = 1'b0, hold_wdata = 1'b0;
    logic [2:0]  wake_en = 3'h0, src_clr = 3'h0, standby_wake_source_flags;
    logic [15:0] gen_out_in = 16'h0, gen_oe_in = 16'h0, gen_out, gen_oe;
    logic [3:0]  mem_out_in = 4'h0, mem_oe_in = 4'h0, mem_out, mem_oe;
    logic        pin_hold_flag, in_standby;
    int          errors = 0, comparisons = 0;
    dsph_seq dut (.sys_clk, .rstn, .standby_req, .wake_en, .wake_nmi, .wake_rtc, .wake_pin,
        .boot_ext, .gen_out_in, .gen_oe_in, .mem_out_in, .mem_oe_in, .hold_rd, .hold_wr,
        .hold_wdata, .src_clr, .gen_out, .gen_oe, .mem_out, .mem_oe,
        .standby_wake_source_flags, .pin_hold_flag, .in_standby);
    always #5 sys_clk = ~sys_clk;
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic enter();
        standby_req = 1'b1;
        step(1);
        standby_req = 1'b0;
        chk({in_standby, pin_hold_flag, standby_wake_source_flags}, 5'h18, "entry");
    endtask
    task automatic t_ram_boot();
        wake_en = 3'h1;
        gen_out_in = 16'ha5c3;
        gen_oe_in = 16'h0ff0;
        mem_out_in = 4'h9;
        mem_oe_in = 4'h6;
        step(2);
        enter();
        gen_out_in = 16'h5a3c;
        gen_oe_in = 16'hf00f;
        mem_out_in = 4'h6;
        mem_oe_in = 4'h9;
        wake_rtc = 1'b1;
        wake_pin = 1'b1;
        step(3);
        chk(in_standby, 1'h1, "disabled source woke");
        chk({gen_out, gen_oe, mem_out, mem_oe}, 40'ha5c30ff096, "pins not held");
        wake_rtc = 1'b0;
        wake_nmi = 1'b1;
        step(1);
        wake_nmi = 1'b0;
        chk({in_standby, standby_wake_source_flags}, 4'h1, "nmi wake");
        hold_wr = 1'b1;
        step(1);
        hold_wr = 1'b0;
        hold_rd = 1'b1;
        step(1);
        hold_rd = 1'b0;
        hold_wr = 1'b1;
        hold_wdata = 1'b1;
        step(1);
        chk(pin_hold_flag, 1'h1, "hold dropped early");
        chk({gen_out, gen_oe, mem_out, mem_oe}, 40'ha5c30ff096, "pins not held");
        hold_wdata = 1'b0;
        step(1);
        hold_wr = 1'b0;
        chk(pin_hold_flag, 1'h0, "hold not released");
        step(1);
        chk({gen_out, gen_oe, mem_out, mem_oe}, 40'h5a3cf00f69, "pins not live");
    endtask
    task automatic t_ext_boot();
        boot_ext = 1'b1;
        wake_en = 3'h6;
        wake_nmi = 1'b1;
        enter();
        mem_out_in = 4'h3;
        mem_oe_in = 4'hc;
        gen_out_in = 16'h1234;
        step(2);
        wake_rtc = 1'b1;
        wake_pin = 1'b0;
        step(1);
        wake_rtc = 1'b0;
        wake_nmi = 1'b0;
        chk({in_standby, standby_wake_source_flags}, 4'h6, "both flags");
        step(1);
        chk({mem_out, mem_oe}, 8'h3c, "memory pins held");
        chk(gen_out, 16'h5a3c, "general pins moved");
        standby_req = 1'b1;
        src_clr = 3'h2;
        step(1);
        standby_req = 1'b0;
        src_clr = 3'h0;
        chk({in_standby, standby_wake_source_flags}, 4'h4, "flag clear");
        gen_oe_in = 16'h0ff0;
        hold_rd = 1'b1;
        step(1);
        hold_rd = 1'b0;
        hold_wr = 1'b1;
        step(1);
        hold_wr = 1'b0;
        chk(pin_hold_flag, 1'h0, "hold not released");
        step(1);
        chk({gen_out, gen_oe, mem_out, mem_oe}, 40'h12340ff03c, "pins not live");
    endtask
    task automatic test_done();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        step(3);
        t_ram_boot();
        t_ext_boot();
        test_done();
    end
    // a hang past several times the scenario length ends the run as a failure
    initial begin
        #5000;
        errors++;
        test_done();
    end
endmodule
bind dsph_seq dsph_seq_checker chk (.sys_clk, .rstn, .standby_req, .wake_en, .wake_nmi,
    .wake_rtc, .wake_pin, .boot_ext, .gen_out_in, .mem_out_in, .hold_rd, .hold_wr,
    .hold_wdata, .src_clr, .gen_out, .gen_oe, .mem_out, .standby_wake_source_flags,
    .pin_hold_flag, .in_standby);
`default_nettype wire
